/* File: rtl/baf_params.svh */
// Offsets, field positions, reset values and timing counts for the
// bus arbitration and fault capture block.
// Assumes a 10 MHz core clock and byte addressing on the register bus.
`ifndef BAF_PARAMS_SVH
`define BAF_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BAF_OFF_CTRL   5'h00
`define BAF_OFF_CMD    5'h04
`define BAF_OFF_STAT   5'h08
`define BAF_OFF_FAULT  5'h0c
`define BAF_OFF_LIMIT  5'h10
`define BAF_OFF_WDOG   5'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BAF_CTRL_FLAG  2
`define BAF_CTRL_ILL   3
`define BAF_CMD_RD     8
`define BAF_CMD_MEM    9
`define BAF_CMD_DAT    10
`define BAF_CMD_LOCK   11
`define BAF_CMD_GO     31
`define BAF_F_PV_CPU   0
`define BAF_F_PV_EXT   1
`define BAF_F_PAR      2
`define BAF_F_EXT_MEM  5
`define BAF_F_SYS0     7
`define BAF_F_EXT_IO   8
`define BAF_F_SYS1_A   13
`define BAF_F_SYS1_B   15

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BAF_CTRL_RST   4'h0
`define BAF_LIMIT_RST  8'hff
`define BAF_WDOG_RST   16'h0000
`define BAF_EDC_BITS   6
`define BAF_CLK_NS     100
`define BAF_BUS_TMO_NS 2000
`define BAF_BUS_TMO_CYC (`BAF_BUS_TMO_NS / `BAF_CLK_NS)

`endif

/* File: rtl/baf_pkg.sv */
// Types shared by the bus arbitration and fault capture block.
// Assumes nothing beyond a SystemVerilog compiler.
package baf_pkg;

	// ------------------------------------------------------------------
	// Own bus cycle sequencer
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		baf_st_idle = 3'h0,
		baf_st_req  = 3'h1,
		baf_st_addr = 3'h2,
		baf_st_data = 3'h3,
		baf_st_gap  = 3'h4
	} baf_state_t;

	// ------------------------------------------------------------------
	// Error checking modes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		baf_edc_none = 2'h0,
		baf_edc_even = 2'h1,
		baf_edc_odd  = 2'h2,
		baf_edc_corr = 2'h3
	} baf_edc_t;

endpackage

/* File: rtl/baf_top.sv */
// Bus requester, four-way arbiter and fault register capture.
// Assumes pins resolved outside; all pin inputs are asynchronous.
//
// Operation
// - Bus request low while the bus is needed, high once our cycle starts.
// - Start a cycle next clock when granted and bus neither busy nor locked.
// - Grant high releases every bus-owner line to high impedance.
// - Busy line frames each cycle; its rising edge captures faults.
// - Busy is undriven in foreign cycles but still watched for faults.
// - Hold line mimics busy in unlocked cycles, undriven in foreign ones.
// - Read-modify-write commands keep hold low across both cycles.
// - Four active-low requests, input 0 highest, input 3 lowest.
// - Grant stays while owner locks, withdrawn on a higher request.
// - A preempting master is granted only after hold is released.
// - Protect violation sets fault bit 0 own cycle, bit 1 foreign.
// - Parity fault in memory cycle sets fault bit 2 at busy rise.
// - Parity or correction mode selectable; none (reset) masks parity.
// - External address fault sets bit 5 for memory, bit 8 for I/O.
// - Address fault out low when an access hits unimplemented space.
// - System fault rising edges set bit 7, or bits 13 and 15.
// - Illegal address output; input in correction mode; reset high-Z.
// - Write permit or protect flag pin, permit mode after reset.
// - Read parity error low; ram-off handshake in correction mode.
// - Timeout pulse on bus time-out or watchdog expiry.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`include "baf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module baf_top (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Own bus ownership
	input  wire logic        cpu_bus_grant_n_in,
	output logic             cpu_bus_request_n_out,
	input  wire logic        bus_cycle_active_n_in,
	output logic             bus_cycle_active_n_out,
	output logic             bus_cycle_active_oe_n_out,
	input  wire logic        bus_hold_n_in,
	output logic             bus_hold_n_out,
	output logic             bus_hold_oe_n_out,
	// Bus owner lines
	output logic      [15:0] info_bus_out,
	output logic             owner_oe_n_out,
	output logic             data_not_instr_out,
	output logic             read_not_write_out,
	output logic             mem_not_io_out,
	input  wire logic        mem_not_io_in,
	output logic             addr_strobe_out,
	output logic             data_strobe_n_out,
	// Arbiter
	input  wire logic [3:0]  master_request_n_in,
	output logic      [3:0]  master_grant_n_out,
	// Fault inputs
	input  wire logic        protect_violation_n_in,
	input  wire logic        parity_fault_n_in,
	input  wire logic        ext_addr_fault_in_n_in,
	input  wire logic [1:0]  system_fault_in,
	// Fault and flag outputs
	output logic             ext_addr_fault_out_n_out,
	input  wire logic        illegal_addr_or_single_err_in,
	output logic             illegal_addr_or_single_err_out,
	output logic             illegal_addr_or_single_err_oe_n_out,
	output logic             write_permit_or_protect_flag_out,
	output logic             read_parity_err_or_ram_off_out,
	output logic             timeout_pulse_out
);
	import baf_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [1:0] baf_prio(input logic [3:0] act);
		baf_prio = act[0] ? 2'h0 : act[1] ? 2'h1 : act[2] ? 2'h2 : 2'h3;
	endfunction

	function automatic logic [3:0] baf_onehot(input logic [1:0] idx);
		baf_onehot = 4'h1 << idx;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [13:0] pin_raw;
	logic [13:0] sync1;
	logic [13:0] sync2;
	assign pin_raw = {cpu_bus_grant_n_in, bus_cycle_active_n_in,
		bus_hold_n_in, mem_not_io_in, master_request_n_in,
		protect_violation_n_in, parity_fault_n_in, ext_addr_fault_in_n_in,
		system_fault_in, illegal_addr_or_single_err_in};

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1 <= 14'h3ff8;
			sync2 <= 14'h3ff8;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
		end
	end

	wire       grant_s  = sync2[13];
	wire       busy_s   = sync2[12];
	wire       hold_s   = sync2[11];
	wire       mem_s    = sync2[10];
	wire [3:0] mreq_n_s = sync2[9:6];
	wire       pv_s     = sync2[5];
	wire       par_s    = sync2[4];
	wire       ext_s    = sync2[3];
	wire [1:0] sys_s    = sync2[2:1];
	wire       single_s = sync2[0];

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic [3:0]  ctrl;
	logic [11:0] cmd;
	logic [7:0]  limit;
	logic [15:0] wd_reload;
	logic [15:0] wd_cnt;
	logic [15:0] fault;
	baf_state_t  state;
	baf_state_t  next_state;

	// One wait cycle per access keeps read data from a flop
	wire req_any = avs_read_in | avs_write_in;
	wire wr_acc  = avs_write_in & ~avs_waitrequest_out;
	wire hit_ctl = avs_address_in == `BAF_OFF_CTRL;
	wire hit_cmd = avs_address_in == `BAF_OFF_CMD;
	wire hit_st  = avs_address_in == `BAF_OFF_STAT;
	wire hit_flt = avs_address_in == `BAF_OFF_FAULT;
	wire hit_lim = avs_address_in == `BAF_OFF_LIMIT;
	wire hit_wd  = avs_address_in == `BAF_OFF_WDOG;
	wire [31:0] rd_mux =
		hit_ctl ? {28'h0, ctrl} :
		hit_cmd ? {20'h0, cmd} :
		hit_st  ? {20'h0, master_grant_n_out, 1'b0, state, ~grant_s,
			~busy_s, ~hold_s, ~timeout_pulse_out} :
		hit_flt ? {16'h0, fault} :
		hit_lim ? {24'h0, limit} :
		hit_wd  ? {16'h0, wd_reload} : 32'h0;
	wire next_waitreq = ~(req_any & avs_waitrequest_out);
	wire go_wr = wr_acc & hit_cmd & avs_writedata_in[`BAF_CMD_GO] &
		(state == baf_st_idle);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0;
			ctrl                <= `BAF_CTRL_RST;
			cmd                 <= 12'h0;
			limit               <= `BAF_LIMIT_RST;
		end else begin
			avs_waitrequest_out <= next_waitreq;
			avs_readdata_out    <= rd_mux;
			if (wr_acc & hit_ctl)
				ctrl <= avs_writedata_in[3:0];
			if (go_wr)
				cmd <= avs_writedata_in[11:0];
			if (wr_acc & hit_lim)
				limit <= avs_writedata_in[7:0];
		end
	end

	wire [7:0] cmd_page = cmd[7:0];
	wire       cmd_rd   = cmd[`BAF_CMD_RD];
	wire       cmd_mem  = cmd[`BAF_CMD_MEM];
	wire       cmd_dat  = cmd[`BAF_CMD_DAT];
	wire       cmd_lock = cmd[`BAF_CMD_LOCK];
	wire       corr     = ctrl[1:0] == baf_edc_corr;

	// ------------------------------------------------------------------
	// Own bus cycle sequencer
	// ------------------------------------------------------------------
	logic [7:0] tmo_cnt;
	logic       second;
	wire start_ok = ~grant_s & busy_s & hold_s;
	wire tmo_hit  = (state == baf_st_req) &
		(tmo_cnt == 8'(`BAF_BUS_TMO_CYC - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			baf_st_idle: if (go_wr) next_state = baf_st_req;
			baf_st_req: begin
				if (tmo_hit)
					next_state = baf_st_idle;
				else if (start_ok)
					next_state = baf_st_addr;
			end
			baf_st_addr: next_state = baf_st_data;
			baf_st_data: begin
				if (cmd_lock & ~second)
					next_state = baf_st_gap;
				else
					next_state = baf_st_idle;
			end
			baf_st_gap: next_state = baf_st_addr;
			default: next_state = baf_st_idle;
		endcase
	end

	wire nx_cyc  = (next_state == baf_st_addr) |
		(next_state == baf_st_data);
	wire nx_own  = nx_cyc | (next_state == baf_st_gap);
	wire nx_drv  = nx_own & ~grant_s;
	wire nx_busy = ~nx_cyc;
	wire nx_illg = nx_cyc & (cmd_page > limit);
	wire par_on  = ~par_s & (ctrl[1:0] != baf_edc_none);
	wire nx_perm = ~((next_state == baf_st_data) & cmd_mem & ~cmd_rd &
		pv_s);
	wire nx_rpar = corr ? single_s :
		~((state == baf_st_data) & cmd_rd & cmd_mem & par_on);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state                     <= baf_st_idle;
			second                    <= 1'b0;
			tmo_cnt                   <= 8'h0;
			cpu_bus_request_n_out     <= 1'b1;
			bus_cycle_active_n_out    <= 1'b1;
			bus_cycle_active_oe_n_out <= 1'b1;
			bus_hold_n_out            <= 1'b1;
			bus_hold_oe_n_out         <= 1'b1;
			owner_oe_n_out            <= 1'b1;
			info_bus_out              <= 16'h0;
			data_not_instr_out        <= 1'b0;
			read_not_write_out        <= 1'b1;
			mem_not_io_out            <= 1'b1;
			addr_strobe_out           <= 1'b0;
			data_strobe_n_out         <= 1'b1;
			ext_addr_fault_out_n_out  <= 1'b1;
		end else begin
			state   <= next_state;
			second  <= (state == baf_st_gap) |
				(second & (state != baf_st_idle));
			tmo_cnt <= (state == baf_st_req) ? tmo_cnt + 8'h1 : 8'h0;
			cpu_bus_request_n_out     <= next_state != baf_st_req;
			bus_cycle_active_n_out    <= nx_busy;
			bus_cycle_active_oe_n_out <= ~nx_drv;
			bus_hold_n_out            <= ~cmd_lock & nx_busy;
			bus_hold_oe_n_out         <= ~nx_drv;
			owner_oe_n_out            <= ~nx_drv;
			info_bus_out              <= {8'h0, cmd_page};
			data_not_instr_out        <= cmd_dat;
			read_not_write_out        <= cmd_rd;
			mem_not_io_out            <= cmd_mem;
			addr_strobe_out           <= next_state == baf_st_addr;
			data_strobe_n_out         <= next_state != baf_st_data;
			ext_addr_fault_out_n_out  <= ~nx_illg;
		end
	end

	// ------------------------------------------------------------------
	// Fault capture
	// ------------------------------------------------------------------
	// Own-cycle marker delayed to line up with the synchronised busy
	logic       busy_q;
	logic       own_d1;
	logic       own_d2;
	logic       cyc_own;
	logic       cyc_mem;
	logic [1:0] sys_q;
	logic       prot_flag;
	wire busy_rise = busy_s & ~busy_q;
	wire busy_fall = ~busy_s & busy_q;
	wire [1:0] sys_rise = sys_s & ~sys_q;
	wire [15:0] flt_set =
		({15'h0, busy_rise & ~pv_s & cyc_own} << `BAF_F_PV_CPU) |
		({15'h0, busy_rise & ~pv_s & ~cyc_own} << `BAF_F_PV_EXT) |
		({15'h0, busy_rise & par_on & cyc_mem} << `BAF_F_PAR) |
		({15'h0, busy_rise & ~ext_s & cyc_mem} << `BAF_F_EXT_MEM) |
		({15'h0, busy_rise & ~ext_s & ~cyc_mem} << `BAF_F_EXT_IO) |
		({15'h0, sys_rise[0]} << `BAF_F_SYS0) |
		({15'h0, sys_rise[1]} << `BAF_F_SYS1_A) |
		({15'h0, sys_rise[1]} << `BAF_F_SYS1_B);
	wire [15:0] flt_clr = (wr_acc & hit_flt) ? avs_writedata_in[15:0] :
		16'h0;
	wire prot_set = busy_rise & cyc_own & ~pv_s & ~cmd_rd;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_q    <= 1'b1;
			own_d1    <= 1'b0;
			own_d2    <= 1'b0;
			cyc_own   <= 1'b0;
			cyc_mem   <= 1'b1;
			sys_q     <= 2'h0;
			fault     <= 16'h0;
			prot_flag <= 1'b0;
		end else begin
			busy_q <= busy_s;
			own_d1 <= ~bus_cycle_active_oe_n_out & ~bus_cycle_active_n_out;
			own_d2 <= own_d1;
			if (!busy_s) begin
				cyc_own <= own_d2;
				cyc_mem <= mem_s;
			end
			sys_q     <= sys_s;
			// Set wins so an event in the clearing cycle survives
			fault     <= (fault & ~flt_clr) | flt_set;
			prot_flag <= prot_set | (prot_flag & ~busy_fall);
		end
	end

	// ------------------------------------------------------------------
	// Dual-purpose pins and watchdog
	// ------------------------------------------------------------------
	wire wd_fire = (wd_reload != 16'h0) & (wd_cnt == 16'h1);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			illegal_addr_or_single_err_out      <= 1'b1;
			illegal_addr_or_single_err_oe_n_out <= 1'b1;
			write_permit_or_protect_flag_out    <= 1'b1;
			read_parity_err_or_ram_off_out      <= 1'b1;
			timeout_pulse_out                   <= 1'b0;
			wd_reload                           <= `BAF_WDOG_RST;
			wd_cnt                              <= `BAF_WDOG_RST;
		end else begin
			illegal_addr_or_single_err_out      <= ~nx_illg;
			illegal_addr_or_single_err_oe_n_out <=
				~(ctrl[`BAF_CTRL_ILL] & ~corr);
			write_permit_or_protect_flag_out    <=
				ctrl[`BAF_CTRL_FLAG] ? prot_flag : nx_perm;
			read_parity_err_or_ram_off_out      <= nx_rpar;
			timeout_pulse_out <= wd_fire | tmo_hit;
			if (wr_acc & hit_wd) begin
				wd_reload <= avs_writedata_in[15:0];
				wd_cnt    <= avs_writedata_in[15:0];
			end else if (wd_fire)
				wd_cnt <= wd_reload;
			else if (wd_cnt != 16'h0)
				wd_cnt <= wd_cnt - 16'h1;
		end
	end

	// ------------------------------------------------------------------
	// Arbiter
	// ------------------------------------------------------------------
	// Preempted lock owner loses grant at once; newcomer waits for hold
	wire [3:0] mreq  = ~mreq_n_s;
	wire       hp_v  = |mreq;
	wire [1:0] hp    = baf_prio(mreq);
	wire       cur_v = ~&master_grant_n_out;
	wire [1:0] cur   = baf_prio(~master_grant_n_out);
	wire [3:0] next_grant_n =
		!cur_v ? ((hp_v & hold_s) ? ~baf_onehot(hp) : 4'hf) :
		!hold_s ? ((hp_v & (hp < cur)) ? 4'hf :
			master_grant_n_out) :
		hp_v ? ~baf_onehot(hp) : 4'hf;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			master_grant_n_out <= 4'hf;
		else
			master_grant_n_out <= next_grant_n;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_req_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state == baf_st_addr) |-> cpu_bus_request_n_out)
		else $error("request still low after cycle start");
	a_start_cond: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state == baf_st_req) ##1 (state == baf_st_addr) |->
		$past(!grant_s && busy_s && hold_s))
		else $error("cycle started without free granted bus");
	a_grant_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
		grant_s |=> owner_oe_n_out && bus_cycle_active_oe_n_out)
		else $error("owner lines driven without grant");
	a_hold_mimic: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!cmd_lock && !bus_hold_oe_n_out) |->
		bus_hold_n_out == bus_cycle_active_n_out)
		else $error("hold does not follow busy");
	a_lock_span: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(state == baf_st_data && cmd_lock && !second) |=>
		(!bus_hold_n_out)[*3])
		else $error("hold released inside locked pair");
	a_arb_prio: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(hold_s && !mreq_n_s[0]) |=> !master_grant_n_out[0])
		else $error("top request not granted");
	a_lock_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!hold_s && master_grant_n_out == 4'hf) |=>
		master_grant_n_out == 4'hf)
		else $error("grant issued while bus locked");
	a_grant_one: assert property (@(posedge clk_in) disable iff (!nrst_in)
		$countones(~master_grant_n_out) <= 1)
		else $error("two grants at once");
	a_pv_own: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(busy_rise && !pv_s && cyc_own) |=> fault[0])
		else $error("own protect fault lost");
	a_par_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(ctrl[1:0] == baf_edc_none && !fault[2]) |=> !fault[2])
		else $error("parity captured with checking off");
	a_ext_mem: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(busy_rise && !ext_s && cyc_mem) |=> fault[5])
		else $error("memory address fault lost");
	a_sys_one: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sys_rise[1] |=> fault[13] && fault[15])
		else $error("system fault 1 edge lost");

endmodule

`default_nettype wire

/* File: test/baf_partner.sv */
// Far side model: external arbiter, another master, fault reporting.
// Assumes the bench resolves the shared wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none

module baf_partner (
	// Clock, reset and watched wires
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic req_n_in,
	input  wire logic busy_in,
	input  wire logic hold_in,
	// Driven lines
	output logic      grant_n_out,
	output logic      busy_n_out = 1'b1,
	output logic      mem_out = 1'b1,
	output logic      pv_n_out,
	output logic      par_n_out,
	output logic      ext_n_out
);
	int         dly = 2;
	bit         en = 1'b1;
	logic [2:0] arm = 3'h0;
	int         cnt, idle, tail;

	// ------------------------------------------------------------------
	// Arbiter
	// ------------------------------------------------------------------
	// Grant kept until the bus has been quiet a while, so a cycle
	// never loses its grant halfway
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			grant_n_out <= 1'b1;
		end else begin
			cnt <= req_n_in ? 0 : cnt + 1;
			idle <= (req_n_in && busy_in && hold_in) ? idle + 1 : 0;
			if (en && !req_n_in && cnt >= dly)
				grant_n_out <= 1'b0;
			else if (idle >= 4)
				grant_n_out <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Memory management faults
	// ------------------------------------------------------------------
	always @(posedge clk_in) begin
		tail <= busy_in ? (tail > 0 ? tail - 1 : 0) : 6;
		if (busy_in && tail == 1)
			arm <= 3'h0;
	end
	assign {ext_n_out, par_n_out, pv_n_out} =
		~(arm & {3{!busy_in || tail > 0}});

	// Another master runs one cycle
	task automatic foreign(input logic [2:0] f, input logic m);
		arm <= f;
		mem_out <= m;
		busy_n_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		busy_n_out <= 1'b1;
		repeat (8) @(posedge clk_in);
		mem_out <= !m;
	endtask
endmodule

`default_nettype wire

/* File: test/baf_top_tb.sv */
// Bench: registers, arbiter requests, own and foreign cycles, faults.
// Assumes baf_partner on the far side and pull-ups on busy and hold.
`include "baf_params.svh"
`timescale 1ns/1ps
`default_nettype none

module baf_top_tb;
	logic        clk_in, nrst_in, avs_read_in, avs_write_in, p_gnt;
	logic [4:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rd;
	logic [3:0]  master_request_n_in, master_grant_n_out;
	logic [1:0]  system_fault_in;
	logic [15:0] info_bus_out;
	logic        avs_waitrequest_out, cpu_bus_request_n_out, p_busy, p_mem;
	logic        bus_cycle_active_n_out, bus_cycle_active_oe_n_out, p_pv;
	logic        bus_hold_n_out, bus_hold_oe_n_out, owner_oe_n_out, p_par;
	logic        data_not_instr_out, read_not_write_out, mem_not_io_out;
	logic        addr_strobe_out, data_strobe_n_out, timeout_pulse_out;
	logic        ext_addr_fault_out_n_out, illegal_addr_or_single_err_out;
	logic        illegal_addr_or_single_err_oe_n_out, ext_hold_n, p_ext;
	logic        write_permit_or_protect_flag_out;
	logic        read_parity_err_or_ram_off_out;
	logic        saw_eo, saw_wp, saw_gap, saw_to;
	int          n_errors, num_checks, cyc, float_bad, n;
	wire         busy_w = p_busy &
		(bus_cycle_active_oe_n_out | bus_cycle_active_n_out);
	wire         hold_w = (bus_hold_oe_n_out | bus_hold_n_out) & ext_hold_n;
	wire         mem_w = owner_oe_n_out ? p_mem : mem_not_io_out;
	wire         ill_w = !illegal_addr_or_single_err_oe_n_out &&
		illegal_addr_or_single_err_out;

	baf_top i_dut (
		.clk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in,
		.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
		.cpu_bus_grant_n_in(p_gnt), .cpu_bus_request_n_out,
		.bus_cycle_active_n_in(busy_w), .bus_cycle_active_n_out,
		.bus_cycle_active_oe_n_out, .bus_hold_n_in(hold_w),
		.bus_hold_n_out, .bus_hold_oe_n_out, .info_bus_out, .owner_oe_n_out,
		.data_not_instr_out, .read_not_write_out, .mem_not_io_out,
		.mem_not_io_in(mem_w), .addr_strobe_out, .data_strobe_n_out,
		.master_request_n_in, .master_grant_n_out,
		.protect_violation_n_in(p_pv), .parity_fault_n_in(p_par),
		.ext_addr_fault_in_n_in(p_ext), .system_fault_in,
		.ext_addr_fault_out_n_out, .illegal_addr_or_single_err_in(ill_w),
		.illegal_addr_or_single_err_out, .illegal_addr_or_single_err_oe_n_out,
		.write_permit_or_protect_flag_out, .read_parity_err_or_ram_off_out,
		.timeout_pulse_out);
	baf_partner i_far (
		.clk_in, .nrst_in, .req_n_in(cpu_bus_request_n_out), .busy_in(busy_w),
		.hold_in(hold_w), .grant_n_out(p_gnt), .busy_n_out(p_busy),
		.mem_out(p_mem), .pv_n_out(p_pv), .par_n_out(p_par), .ext_n_out(p_ext));

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [3:0] prio(input logic [3:0] r);
		for (int i = 0; i < 4; i++)
			if (!r[i])
				return ~(4'h1 << i);
		return 4'hf;
	endfunction
	task automatic acc(input logic w, input logic [4:0] a, input int d);
		int k;
		k = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		do begin
			@(posedge clk_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 50);
		if (k >= 50)
			n_errors++;
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic fault(input int exp);
		acc(1'b0, `BAF_OFF_FAULT, 0);
		chk(rd, exp);
		acc(1'b1, `BAF_OFF_FAULT, 32'hffff);
	endtask
	// One own cycle; wide window catches the locked pair and its gap
	task automatic own(input int cmd, input logic [2:0] f);
		int k;
		k = 0;
		i_far.dly = $urandom % 8;
		i_far.arm <= f;
		acc(1'b1, `BAF_OFF_CMD, cmd | 32'h80000000);
		@(posedge clk_in);
		chk(cpu_bus_request_n_out, 1'b0);
		while (busy_w !== 1'b0 && k < 60) begin
			@(posedge clk_in);
			k++;
		end
		chk({cpu_bus_request_n_out, hold_w}, 2'h2);
		{saw_eo, saw_wp, saw_gap} = 3'h0;
		repeat (12) begin
			@(posedge clk_in);
			saw_eo |= !ext_addr_fault_out_n_out;
			saw_wp |= !write_permit_or_protect_flag_out;
			saw_gap |= busy_w && !hold_w;
		end
		repeat (6) @(posedge clk_in);
	endtask

	initial clk_in = 1'b0;
	always #50 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (!p_busy && {owner_oe_n_out, bus_cycle_active_oe_n_out,
		    bus_hold_oe_n_out} !== 3'h7)
			float_bad++;
		if (cyc == 6000) begin
			n_errors++;
			results();
		end
	end

	initial begin
		{nrst_in, avs_read_in, avs_write_in, ext_hold_n} = 4'h1;
		{avs_address_in, avs_writedata_in, system_fault_in} = 0;
		master_request_n_in = 4'hf;
		n = $urandom(76472);
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		chk(master_grant_n_out, 4'hf);
		chk({owner_oe_n_out, timeout_pulse_out}, 2'h2);
		chk(illegal_addr_or_single_err_oe_n_out, 1'b1);
		acc(1'b0, `BAF_OFF_CTRL, 0);
		chk(rd, 0);
		acc(1'b0, 5'h18, 0);
		chk(rd, 0);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			master_request_n_in <= 4'($urandom);
			repeat (5) @(posedge clk_in);
			chk(master_grant_n_out, prio(master_request_n_in));
		end
		// Owner granted with hold free first, then locked
		master_request_n_in <= 4'hb;
		repeat (5) @(posedge clk_in);
		ext_hold_n <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk(master_grant_n_out, 4'hb);
		master_request_n_in <= 4'ha;
		repeat (5) @(posedge clk_in);
		chk(master_grant_n_out, 4'hf);
		ext_hold_n <= 1'b1;
		repeat (5) @(posedge clk_in);
		chk(master_grant_n_out, 4'he);
		master_request_n_in <= 4'hf;
		$display("test arbiter done");
		own(32'h620, 3'h0);
		chk({saw_wp, saw_eo, saw_gap}, 3'h4);
		own(32'he20, 3'h0);
		chk(saw_gap, 1'b1);
		own(32'h701, 3'h1);
		fault(32'h1);
		acc(1'b1, `BAF_OFF_LIMIT, 5);
		own(32'h720, 3'h0);
		chk(saw_eo, 1'b1);
		acc(1'b1, `BAF_OFF_FAULT, 32'hffff);
		for (int m = 0; m < 3; m++) begin
			acc(1'b1, `BAF_OFF_CTRL, m);
			own(32'h701, 3'h2);
			fault(m ? 32'h4 : 0);
		end
		$display("test own cycles done");
		float_bad = 0;
		i_far.foreign(3'h1, 1'b1);
		fault(32'h2);
		i_far.foreign(3'h4, 1'b1);
		fault(32'h20);
		i_far.foreign(3'h4, 1'b0);
		fault(32'h100);
		chk(float_bad, 0);
		for (int j = 0; j < 2; j++) begin
			system_fault_in <= 2'(1 << j);
			repeat (4) @(posedge clk_in);
			system_fault_in <= 2'h0;
			repeat (4) @(posedge clk_in);
			fault(j ? 32'ha000 : 32'h80);
		end
		$display("test foreign and system faults done");
		i_far.en = 1'b0;
		saw_to = 1'b0;
		acc(1'b1, `BAF_OFF_CMD, 32'h80000701);
		repeat (40) begin
			@(posedge clk_in);
			saw_to |= timeout_pulse_out === 1'b1;
		end
		chk(saw_to, 1'b1);
		$display("test time-out done");
		results();
	end
endmodule

`default_nettype wire
